// ===== src/ccr_pkg.sv
// package for the ccd frame readout sequencer: geometry and timing constants
package ccr_pkg;

  // ----------------------------------------------------------------
  // sensor geometry
  // ----------------------------------------------------------------
  localparam int unsigned COLUMNS = 1552;
  localparam int unsigned ROWS = 1032;
  localparam logic [10:0] HREG_LEN = 11'd1564;
  localparam logic [10:0] ROW_COUNT = 11'd1032;
  localparam logic [10:0] LEAD_DUMMY = 11'd10;
  localparam logic [10:0] DARK_LEFT = 11'd4;
  localparam logic [10:0] DARK_RIGHT = 11'd12;
  localparam logic [10:0] TRAIL_DUMMY = 11'd2;
  localparam logic [10:0] ACTIVE_COLS = 11'd1536;
  localparam logic [10:0] DARK_ROWS = 11'd4;
  localparam logic [10:0] ACTIVE_ROWS = 11'd1024;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned MAX_PIXEL_MHZ = 10;
  // one phase step per tick; a pixel takes five ticks, so the pixel rate
  // is clk / (5 * TICK_CYCLES); TICK_CYCLES is sized for four ticks, rounded up so it never exceeds the maximum
  localparam int unsigned TICK_CYCLES_INT =
    (CLK_MHZ + 4 * MAX_PIXEL_MHZ - 1) / (4 * MAX_PIXEL_MHZ);
  localparam logic [7:0] TICK_CYCLES = 8'(TICK_CYCLES_INT);
  localparam logic [7:0] TICK_RESET = 8'h00;

  // pixel class reported with each sample strobe
  localparam logic [2:0] PIX_DUMMY = 3'h0;
  localparam logic [2:0] PIX_DARK = 3'h1;
  localparam logic [2:0] PIX_ACTIVE = 3'h2;
  localparam logic [2:0] PIX_DARK_ROW = 3'h3;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_EXPO  = 6'b000010,
    ST_VXFER = 6'b000100,
    ST_HSHFT = 6'b001000,
    ST_SAMP  = 6'b010000,
    ST_RESET = 6'b100000
  } ccr_state_type;

endpackage

// ===== src/ccr_sequencer.sv
// readout sequencer that drives the full-frame ccd clock pins
//
// Summary of operation
// RL1 - vertical phases held low and idle throughout exposure
// RL2 - shutter open only during integration, closed through readout
// RL3 - frame read one row at a time through the horizontal register
// RL4 - row enters on vertical phase two fall, horizontal one held high
// RL5 - horizontal phases toggled complementary, one pixel per cycle
// RL6 - sensor dumps a packet on each horizontal phase two fall
// RL7 - reset gate pulsed only after the sample strobe
// RL8 - array is 1552 columns of 1032 elements
// RL9 - 1564 horizontal shifts empty one row
// RL10 - first 4 and last 12 column pixels of a row are dark
// RL11 - 4 dark rows begin and 4 dark rows end each frame
// RL12 - 10 leading dummy pixels per row
// RL13 - two trailing dummy pixels per row
// RL14 - active region 1536 by 1024 inside the borders
// RL15 - pixel rate kept at or below 10 MHz
// RL16 - horizontal and vertical clocking never interleave
module ccr_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic expose_done,
  output logic busy,
  output logic frame_done,
  // sensor clock pins
  output logic vertical_phase_one,
  output logic vertical_phase_two,
  output logic horizontal_phase_one,
  output logic horizontal_phase_two,
  output logic reset_gate,
  output logic shutter_open,
  // sampling electronics
  output logic sample_strobe,
  output logic [2:0] pixel_class,
  output logic [10:0] pixel_col,
  output logic [10:0] pixel_row
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ccr_pkg::ccr_state_type st;
    logic [7:0] tick;
    logic [1:0] phase;
    logic [10:0] col;
    logic [10:0] row;
    logic v1;
    logic v2;
    logic h1;
    logic h2;
    logic rg;
    logic shut;
    logic strobe;
    logic [2:0] cls;
    logic [10:0] out_col;
    logic [10:0] out_row;
    logic done;
  } ccr_regs_type;

  ccr_regs_type r;
  ccr_regs_type next_r;
  logic tick_en;
  logic dark_row;

  assign tick_en = (r.tick == ccr_pkg::TICK_CYCLES - 8'h01);
  assign dark_row = (r.row < ccr_pkg::DARK_ROWS) ||
    (r.row >= ccr_pkg::ROW_COUNT - ccr_pkg::DARK_ROWS);

  // ----------------------------------------------------------------
  // pixel classification
  // ----------------------------------------------------------------
  function automatic logic [2:0] classify(input logic [10:0] c,
                                          input logic drow);
    logic [10:0] k;
    k = c - ccr_pkg::LEAD_DUMMY;
    // RL12 RL13 leading and trailing dummies
    if (c < ccr_pkg::LEAD_DUMMY ||
        c >= ccr_pkg::HREG_LEN - ccr_pkg::TRAIL_DUMMY) begin
      classify = ccr_pkg::PIX_DUMMY;
    // RL11 dark border rows
    end else if (drow) begin
      classify = ccr_pkg::PIX_DARK_ROW;
    // RL10 RL14 dark columns bracket active ones
    end else if (k < ccr_pkg::DARK_LEFT ||
                 k >= ccr_pkg::DARK_LEFT + ccr_pkg::ACTIVE_COLS) begin
      classify = ccr_pkg::PIX_DARK;
    end else begin
      classify = ccr_pkg::PIX_ACTIVE;
    end
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.strobe = 1'b0;
    next_r.done = 1'b0;
    // RL15 phase steps paced by the divider
    next_r.tick = tick_en ? ccr_pkg::TICK_RESET : r.tick + 8'h01;
    unique case (r.st)
      ccr_pkg::ST_IDLE: begin
        next_r.tick = ccr_pkg::TICK_RESET;
        if (start) begin
          next_r.st = ccr_pkg::ST_EXPO;
          // RL2 light only while integrating
          next_r.shut = 1'b1;
        end
      end
      ccr_pkg::ST_EXPO: begin
        // RL1 vertical clocks held low
        next_r.v1 = 1'b0;
        next_r.v2 = 1'b0;
        if (expose_done) begin
          next_r.shut = 1'b0;
          next_r.st = ccr_pkg::ST_VXFER;
          next_r.row = 11'h000;
          next_r.phase = 2'h0;
          next_r.tick = ccr_pkg::TICK_RESET;
        end
      end
      ccr_pkg::ST_VXFER: begin
        // RL4 RL16 h1 high, h2 low, no shifting during row move
        next_r.h1 = 1'b1;
        next_r.h2 = 1'b0;
        if (tick_en) begin
          next_r.phase = r.phase + 2'h1;
          unique case (r.phase)
            2'h0: next_r.v1 = 1'b1;
            2'h1: next_r.v2 = 1'b1;
            2'h2: next_r.v1 = 1'b0;
            2'h3: begin
              // RL3 one row lands as v2 falls
              next_r.v2 = 1'b0;
              next_r.st = ccr_pkg::ST_HSHFT;
              next_r.col = 11'h000;
            end
          endcase
        end
      end
      ccr_pkg::ST_HSHFT: begin
        // RL5 RL6 complementary swap; h2 falls to present a packet
        if (tick_en) begin
          next_r.h1 = ~r.h1;
          next_r.h2 = ~r.h2;
          if (r.h2) begin
            next_r.st = ccr_pkg::ST_SAMP;
          end
        end
      end
      ccr_pkg::ST_SAMP: begin
        if (tick_en) begin
          next_r.strobe = 1'b1;
          next_r.cls = classify(r.col, dark_row);
          next_r.out_col = r.col;
          next_r.out_row = r.row;
          next_r.st = ccr_pkg::ST_RESET;
          next_r.rg = 1'b0;
        end
      end
      ccr_pkg::ST_RESET: begin
        // RL7 reset gate follows the sample strobe
        if (tick_en) begin
          if (!r.rg) begin
            next_r.rg = 1'b1;
          end else begin
            next_r.rg = 1'b0;
            // RL9 all horizontal elements shifted
            if (r.col == ccr_pkg::HREG_LEN - 11'h001) begin
              // RL8 every vertical element transferred
              if (r.row == ccr_pkg::ROW_COUNT - 11'h001) begin
                next_r.st = ccr_pkg::ST_IDLE;
                next_r.done = 1'b1;
              end else begin
                next_r.row = r.row + 11'h001;
                next_r.phase = 2'h0;
                next_r.st = ccr_pkg::ST_VXFER;
              end
            end else begin
              next_r.col = r.col + 11'h001;
              next_r.st = ccr_pkg::ST_HSHFT;
            end
          end
        end
      end
      default: next_r.st = ccr_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
      r.st <= ccr_pkg::ST_IDLE;
      // h1 rests high so a row can land at any time
      r.h1 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign busy = (r.st != ccr_pkg::ST_IDLE);
  assign frame_done = r.done;
  assign vertical_phase_one = r.v1;
  assign vertical_phase_two = r.v2;
  assign horizontal_phase_one = r.h1;
  assign horizontal_phase_two = r.h2;
  assign reset_gate = r.rg;
  assign shutter_open = r.shut;
  assign sample_strobe = r.strobe;
  assign pixel_class = r.cls;
  assign pixel_col = r.out_col;
  assign pixel_row = r.out_row;

endmodule

// ===== bench/ccr_seq_props.sv
// port assertions for the ccd readout sequencer
module ccr_seq_props (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic expose_done,
  input wire logic busy,
  input wire logic frame_done,
  // sensor clock pins
  input wire logic vertical_phase_one,
  input wire logic vertical_phase_two,
  input wire logic horizontal_phase_one,
  input wire logic horizontal_phase_two,
  input wire logic reset_gate,
  input wire logic shutter_open,
  // sampling electronics
  input wire logic sample_strobe,
  input wire logic [2:0] pixel_class,
  input wire logic [10:0] pixel_col,
  input wire logic [10:0] pixel_row
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic v_any = vertical_phase_one || vertical_phase_two;
  a_expo_v_low: assert property (shutter_open |-> !v_any)
    else $error("vertical clock moved during exposure");
  a_dark_readout: assert property (
    (v_any || horizontal_phase_two) |-> !shutter_open)
    else $error("shutter open in readout");
  a_start_shutter: assert property (
    !busy && start |=> shutter_open)
    else $error("shutter not opened on start");
  a_expose_end: assert property (
    shutter_open && expose_done |=> !shutter_open)
    else $error("shutter still open after exposure");
  a_done_idle: assert property (frame_done |-> !busy)
    else $error("frame done while still busy");
  a_row_load_h1: assert property (
    $fell(vertical_phase_two) |-> horizontal_phase_one &&
    !horizontal_phase_two) else $error("row loaded without h1 high");
  a_h_complement: assert property (
    horizontal_phase_one != horizontal_phase_two)
    else $error("h phases not complementary");
  a_packet_sample: assert property (
    $fell(horizontal_phase_two) |-> ##3 sample_strobe)
    else $error("no sample after packet");
  a_reset_after: assert property (
    $rose(reset_gate) |-> $past(sample_strobe, 3))
    else $error("reset gate before sample");
  a_row_range: assert property (
    sample_strobe |-> pixel_row < ccr_pkg::ROW_COUNT)
    else $error("row out of range");
  a_class_legal: assert property (
    sample_strobe |-> pixel_class <= ccr_pkg::PIX_DARK_ROW)
    else $error("pixel class out of range");
  a_tick_hold: assert property (
    $changed(horizontal_phase_two) |=>
    $stable(horizontal_phase_two)[*2]) else $error("h2 too fast");
  a_no_interleave: assert property (
    v_any |-> horizontal_phase_one && !horizontal_phase_two)
    else $error("h moved in row move");
  a_col_range: assert property (
    sample_strobe |-> pixel_col < ccr_pkg::HREG_LEN)
    else $error("column out of range");
  c_sample: cover property (sample_strobe);
  c_row_load: cover property ($fell(vertical_phase_two));
  c_reset_gate: cover property ($rose(reset_gate));
endmodule
bind ccr_sequencer ccr_seq_props u_ccr_seq_props (
  .clk(clk),
  .rstn(rstn),
  .start(start),
  .expose_done(expose_done),
  .busy(busy),
  .frame_done(frame_done),
  .vertical_phase_one(vertical_phase_one),
  .vertical_phase_two(vertical_phase_two),
  .horizontal_phase_one(horizontal_phase_one),
  .horizontal_phase_two(horizontal_phase_two),
  .reset_gate(reset_gate),
  .shutter_open(shutter_open),
  .sample_strobe(sample_strobe),
  .pixel_class(pixel_class),
  .pixel_col(pixel_col),
  .pixel_row(pixel_row)
);

// ===== bench/ccr_sensor_model.sv
// behavioural sensor: counts rows loaded and packets on the output node
module ccr_sensor_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sensor clock pins
  input wire logic v2,
  input wire logic h1,
  input wire logic h2,
  input wire logic rg,
  // observed charge flow
  output int row_cnt,
  output int pix_cnt,
  output logic node_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic v2_q = 1'b0;
  logic h2_q = 1'b0;
  always @(posedge clk) begin
    v2_q <= v2;
    h2_q <= h2;
    // one row enters on v2 fall with h1 high
    if (v2_q && !v2 && h1 && row_cnt < 1032) begin
      row_cnt <= row_cnt + 1;
      pix_cnt <= 0;
    end
    // packet to node on h2 fall, 1564 per row
    if (h2_q && !h2 && pix_cnt < 1564) begin
      pix_cnt <= pix_cnt + 1;
      node_full <= 1'b1;
    end
    if (rg) node_full <= 1'b0;
    if (!rstn) {row_cnt, pix_cnt, node_full} <= '0;
  end
endmodule

// ===== bench/tb_ccr_sequencer.sv
// self-checking bench for the ccd readout sequencer
module tb_ccr_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, start, expose_done, busy, frame_done, v1, v2, h1, h2;
  logic rg, sh, strobe, node_full;
  logic [2:0] cls;
  logic [10:0] col, row;
  int row_cnt, pix_cnt, miscompares, samples_checked, cycles;
  logic [7:0] lfsr = 8'h3e;
  ccr_sequencer u_ccr_sequencer (.clk(clk), .rstn(rstn), .start(start),
    .expose_done(expose_done), .busy(busy), .frame_done(frame_done),
    .vertical_phase_one(v1), .vertical_phase_two(v2),
    .horizontal_phase_one(h1), .horizontal_phase_two(h2), .reset_gate(rg),
    .shutter_open(sh), .sample_strobe(strobe), .pixel_class(cls),
    .pixel_col(col), .pixel_row(row));
  ccr_sensor_model u_ccr_sensor_model (.clk(clk), .rstn(rstn), .v2(v2),
    .h1(h1), .h2(h2), .rg(rg), .row_cnt(row_cnt), .pix_cnt(pix_cnt),
    .node_full(node_full));
  task automatic chk(string nm, logic [10:0] seen, logic [10:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // dark and dummy borders around the active region
  function automatic logic [2:0] exp_class(int c, int r);
    if (c < 10 || c >= 1562) return ccr_pkg::PIX_DUMMY;
    if (r < 4 || r >= 1028) return ccr_pkg::PIX_DARK_ROW;
    if (c < 14 || c >= 1550) return ccr_pkg::PIX_DARK;
    return ccr_pkg::PIX_ACTIVE;
  endfunction
  function automatic logic [7:0] lfsr_next(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
    lfsr = lfsr_next(lfsr);
  endtask
  task automatic pixels(int r, int n);
    int w;
    for (int c = 0; c < n; c++) begin
      w = 0;
      while (strobe !== 1'b1 && w < 200) begin
        step(1);
        // readout must refuse both requests, so they are driven at random
        start = lfsr[0];
        expose_done = lfsr[1];
        w++;
      end
      chk("col", col, 11'(c));
      chk("row", row, 11'(r));
      chk("rows in", 11'(row_cnt), 11'(r + 1));
      chk("class", 11'(cls), 11'(exp_class(c, r)));
      chk("packets", 11'(pix_cnt), 11'(c + 1));
      chk("node", 11'(node_full), 11'h1);
      chk("done", 11'(frame_done), 11'h0);
      step(1);
    end
    start = 0;
    expose_done = 0;
  endtask
  task automatic frame();
    // expose_done alongside start must not end a not yet begun exposure
    step(1 + lfsr[3:0]);
    start = 1;
    expose_done = 1;
    step(1);
    start = 0;
    expose_done = 0;
    step(1 + lfsr[4:0]);
    chk("shutter", 11'(sh), 11'h1);
    chk("v1 expo", 11'(v1), 11'h0);
    chk("busy", 11'(busy), 11'h1);
    expose_done = 1;
    step(1);
    expose_done = 0;
    step(1);
    chk("shutter off", 11'(sh), 11'h0);
  endtask
  task automatic idle_check();
    chk("h1 rest", 11'(h1), 11'h1);
    chk("h2 rest", 11'(h2), 11'h0);
    chk("idle", 11'({busy, v1, v2, rg, sh, strobe}), 11'h0);
    chk("done idle", 11'(frame_done), 11'h0);
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {rstn, start, expose_done} = '0;
    step(3);
    rstn = 1;
    idle_check();
    $display("test 1 done");
    frame();
    pixels(0, 1564);
    // a second start in mid-readout is ignored
    step(1);
    start = 1;
    step(1);
    start = 0;
    pixels(1, 20);
    $display("test 2 done");
    rstn = 0;
    step(2);
    rstn = 1;
    idle_check();
    frame();
    pixels(0, 16);
    $display("test 3 done");
    end_sim();
  end
endmodule
